// ===== hw/atgb_pkg.sv
/*
 * atgb_pkg: constants, register map, band table and state layout for the
 * automatic temperature gain band tracker.
 * Assumes a 32-bit APB register bus and one 50 MHz clock.
 */
package atgb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;     // enables
    localparam logic [7:0] ADDR_FILT = 8'h04;     // filter count limit
    localparam logic [7:0] ADDR_TLOW = 8'h08;     // low threshold
    localparam logic [7:0] ADDR_THIGH = 8'h0C;    // high threshold
    localparam logic [7:0] ADDR_RGAIN = 8'h10;    // room gain code
    localparam logic [7:0] ADDR_DELTA = 8'h14;    // hot and cold deltas
    localparam logic [7:0] ADDR_ROFF = 8'h18;     // room offset code
    localparam logic [7:0] ADDR_STAT = 8'h1C;     // status
    localparam logic [7:0] ADDR_GOUT = 8'h20;     // applied gain code

    // field positions
    localparam int CTRL_AUTO_BIT = 0;             // automatic gain enable
    localparam int STAT_CAL_BIT = 8;              // recalibration flag
    localparam int STAT_CNT_LSB = 16;             // filter counter
    localparam int DELTA_COLD_LSB = 8;            // cold delta field

    // widths
    localparam int GAIN_W = 10;
    localparam int OFF_W = 8;
    localparam int DELTA_W = 5;
    localparam int CNT_W = 3;
    localparam int POS_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // band table, position 0 is the coldest band, 14 the hottest
    localparam logic [POS_W-1:0] POS_ROOM = 4'h5;
    localparam logic [POS_W-1:0] POS_MAX = 4'hE;
    localparam logic [POS_W-1:0] HOT_STEPS = 4'h8;
    localparam logic [POS_W-1:0] COLD_STEPS = 4'h4;
    localparam logic [7:0] BAND_LOW [15] = '{8'h00, 8'h6B, 8'h73, 8'h7A, 8'h82,
        8'h8A, 8'h92, 8'h98, 8'h9E, 8'hA4, 8'hAA, 8'hB1, 8'hB7, 8'hBD, 8'hC3};
    localparam logic [7:0] BAND_HIGH [15] = '{8'h73, 8'h7A, 8'h82, 8'h8A, 8'h92,
        8'h98, 8'h9E, 8'hA4, 8'hAA, 8'hB1, 8'hB7, 8'hBD, 8'hC3, 8'hC9, 8'hFF};

    // reset values
    localparam logic [GAIN_W-1:0] RST_GAIN = 10'h200;
    localparam logic [OFF_W-1:0] RST_OFF = 8'h00;
    localparam logic [CNT_W-1:0] RST_LIMIT = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // complete state of the tracker
    typedef struct packed {
        logic auto_gain_comp_enable;              // automatic mode
        logic [CNT_W-1:0] filter_count_limit;     // configured limit
        logic [7:0] low_threshold_reg;            // band low threshold
        logic [7:0] high_threshold_reg;           // band high threshold
        logic [GAIN_W-1:0] room_gain_code;        // factory room gain
        logic [DELTA_W-1:0] hot_gain_delta;       // signed hot delta
        logic [DELTA_W-1:0] cold_gain_delta;      // signed cold delta
        logic [OFF_W-1:0] room_offset_code;       // fixed offset code
        logic [POS_W-1:0] band_pos;               // current band
        logic [CNT_W-1:0] filt_cnt;               // filter counter
        logic cal_flag;                           // recalibration request
        logic [GAIN_W-1:0] gain_code;             // applied gain
        logic [31:0] prdata;                      // read data
        logic pslverr;                            // unmapped access
    } atgb_state_s;

endpackage : atgb_pkg

// ===== hw/atgb_top.sv
/*
 * atgb_top: automatic temperature gain band tracker with APB registers.
 * Assumes chip temperature results arrive on the same clock as one-cycle
 * valid pulses, and that the gain and offset codes feed the chain directly.
 */
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ns
module atgb_top
    import atgb_pkg::*;
#(
    parameter int TEMP_W = 16                     // chip temperature width
)(
    input wire logic pclk,                        // system clock
    input wire logic presetn,                     // async reset, active low
    input wire logic psel,                        // apb select
    input wire logic penable,                     // apb access phase
    input wire logic pwrite,                      // apb direction
    input wire logic [7:0] paddr,                 // apb byte address
    input wire logic [31:0] pwdata,               // apb write data
    output logic [31:0] prdata,                   // apb read data
    output logic pready,                          // apb ready
    output logic pslverr,                         // apb error
    input wire logic temp_valid,                  // new chip temperature
    input wire logic [TEMP_W-1:0] chip_temp_result, // chip temperature
    output logic [atgb_pkg::GAIN_W-1:0] gain_code,  // applied gain code
    output logic [atgb_pkg::OFF_W-1:0] offset_code, // applied offset code
    output logic cal_request                      // recalibration request
);
    import atgb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check
    generate
        if (TEMP_W < 8)
        begin : g_bad_width
            $error("chip temperature narrower than one byte");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // gain for a band position
    function automatic logic [GAIN_W-1:0] band_gain(
        input logic [POS_W-1:0] pos,
        input logic [GAIN_W-1:0] room,
        input logic [DELTA_W-1:0] hot,
        input logic [DELTA_W-1:0] cold
    );
        logic [POS_W-1:0] k;
        logic signed [10:0] prod;
        logic signed [11:0] sum;
        k = 4'h0;
        prod = 11'sh000;
        if (pos > POS_ROOM)
        begin
            // eighths of hot delta, full at the last step
            k = ((pos - POS_ROOM) > HOT_STEPS) ? HOT_STEPS : pos - POS_ROOM;
            prod = 11'($signed(hot) * $signed({1'b0, k})) >>> 3;
        end
        else if (pos < POS_ROOM)
        begin
            // quarters of cold delta, full at the last step
            k = ((POS_ROOM - pos) > COLD_STEPS) ? COLD_STEPS : POS_ROOM - pos;
            prod = 11'($signed(cold) * $signed({1'b0, k})) >>> 2;
        end
        sum = $signed({2'b00, room}) + 12'(prod);
        // clamp to the code range
        if (sum < 0)
            band_gain = '0;
        else if (sum > 12'sd1023)
            band_gain = '1;
        else
            band_gain = sum[GAIN_W-1:0];
    endfunction : band_gain

    ////////////////////////////////////////////////////////////////////////////
    // state
    atgb_state_s st;                              // registered state
    atgb_state_s next_st;                         // next state
    logic wr_en;                                  // write access phase
    logic rd_setup;                               // read setup phase
    logic [7:0] temp_hi;                          // compared byte
    logic above;                                  // over high threshold
    logic below;                                  // under low threshold
    logic [CNT_W:0] cnt_inc;                      // counter plus one
    logic filt_event;                             // threshold event
    logic [POS_W-1:0] new_pos;                    // band after event

    // apb decode and the shared threshold compare
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign temp_hi = chip_temp_result[TEMP_W-1 -: 8];
    assign above = temp_hi > st.high_threshold_reg;
    assign below = temp_hi < st.low_threshold_reg;
    assign cnt_inc = {1'b0, st.filt_cnt} + 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        next_st = st;
        filt_event = 1'b0;
        new_pos = st.band_pos;
        // filter counter shared by both modes
        if (temp_valid)
        begin
            if (above || below)
            begin
                if (cnt_inc > {1'b0, st.filter_count_limit})
                begin
                    filt_event = 1'b1;
                    next_st.filt_cnt = '0;
                end
                else
                    next_st.filt_cnt = cnt_inc[CNT_W-1:0];
            end
            else if (st.filt_cnt != '0)
                next_st.filt_cnt = st.filt_cnt - 3'h1;
        end
        // software writes
        if (wr_en)
        begin
            if (paddr == ADDR_CTRL)
            begin
                next_st.auto_gain_comp_enable = pwdata[CTRL_AUTO_BIT];
                // entering auto mode starts from the room band
                if (pwdata[CTRL_AUTO_BIT] && !st.auto_gain_comp_enable)
                begin
                    next_st.band_pos = POS_ROOM;
                    next_st.low_threshold_reg = BAND_LOW[POS_ROOM];
                    next_st.high_threshold_reg = BAND_HIGH[POS_ROOM];
                    next_st.filt_cnt = '0;
                end
            end
            else if (paddr == ADDR_FILT)
                next_st.filter_count_limit = pwdata[CNT_W-1:0];
            else if (paddr == ADDR_TLOW && !st.auto_gain_comp_enable)
                next_st.low_threshold_reg = pwdata[7:0];
            else if (paddr == ADDR_THIGH && !st.auto_gain_comp_enable)
                next_st.high_threshold_reg = pwdata[7:0];
            else if (paddr == ADDR_RGAIN)
                next_st.room_gain_code = pwdata[GAIN_W-1:0];
            else if (paddr == ADDR_DELTA)
            begin
                next_st.hot_gain_delta = pwdata[DELTA_W-1:0];
                next_st.cold_gain_delta = pwdata[DELTA_COLD_LSB +: DELTA_W];
            end
            else if (paddr == ADDR_ROFF)
                next_st.room_offset_code = pwdata[OFF_W-1:0];
            else if (paddr == ADDR_STAT && pwdata[STAT_CAL_BIT])
                next_st.cal_flag = 1'b0;
        end
        // threshold event: band step in auto mode, request otherwise
        if (filt_event)
        begin
            if (st.auto_gain_comp_enable)
            begin
                if (above && st.band_pos != POS_MAX)
                    new_pos = st.band_pos + 4'h1;
                else if (below && st.band_pos != '0)
                    new_pos = st.band_pos - 4'h1;
                next_st.band_pos = new_pos;
                // overlapping neighbour thresholds loaded with the step
                next_st.low_threshold_reg = BAND_LOW[new_pos];
                next_st.high_threshold_reg = BAND_HIGH[new_pos];
            end
            else
                next_st.cal_flag = 1'b1;
        end
        // gain follows the band; manual mode applies the room code
        if (next_st.auto_gain_comp_enable)
            next_st.gain_code = band_gain(next_st.band_pos, next_st.room_gain_code,
                next_st.hot_gain_delta, next_st.cold_gain_delta);
        else
            next_st.gain_code = next_st.room_gain_code;
        // read data prepared in the setup phase
        next_st.prdata = '0;
        next_st.pslverr = 1'b0;
        if (rd_setup)
        begin
            if (paddr == ADDR_CTRL)
                next_st.prdata[CTRL_AUTO_BIT] = st.auto_gain_comp_enable;
            else if (paddr == ADDR_FILT)
                next_st.prdata[CNT_W-1:0] = st.filter_count_limit;
            else if (paddr == ADDR_TLOW)
                next_st.prdata[7:0] = st.low_threshold_reg;
            else if (paddr == ADDR_THIGH)
                next_st.prdata[7:0] = st.high_threshold_reg;
            else if (paddr == ADDR_RGAIN)
                next_st.prdata[GAIN_W-1:0] = st.room_gain_code;
            else if (paddr == ADDR_DELTA)
            begin
                next_st.prdata[DELTA_W-1:0] = st.hot_gain_delta;
                next_st.prdata[DELTA_COLD_LSB +: DELTA_W] = st.cold_gain_delta;
            end
            else if (paddr == ADDR_ROFF)
                next_st.prdata[OFF_W-1:0] = st.room_offset_code;
            else if (paddr == ADDR_STAT)
            begin
                next_st.prdata[POS_W-1:0] = st.band_pos;
                next_st.prdata[STAT_CAL_BIT] = st.cal_flag;
                next_st.prdata[STAT_CNT_LSB +: CNT_W] = st.filt_cnt;
            end
            else if (paddr == ADDR_GOUT)
                next_st.prdata[GAIN_W-1:0] = st.gain_code;
            else
                next_st.pslverr = 1'b1;
        end
        else if (psel)
        begin
            // hold the answer through the access phase
            next_st.prdata = st.prdata;
            next_st.pslverr = st.pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.filter_count_limit <= RST_LIMIT;
            st.low_threshold_reg <= BAND_LOW[POS_ROOM];
            st.high_threshold_reg <= BAND_HIGH[POS_ROOM];
            st.room_gain_code <= RST_GAIN;
            st.room_offset_code <= RST_OFF;
            st.band_pos <= POS_ROOM;
            st.gain_code <= RST_GAIN;
        end
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = st.prdata;
    assign pslverr = st.pslverr & psel & penable;
    assign pready = psel & penable;
    assign gain_code = st.gain_code;
    assign offset_code = st.room_offset_code;
    assign cal_request = st.cal_flag & ~st.auto_gain_comp_enable;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // gain holds the full delta in the saturating bands
    a_hot_full_gain: assert property (
        st.auto_gain_comp_enable && st.band_pos >= POS_ROOM + HOT_STEPS
        |-> st.gain_code == band_gain(POS_ROOM + HOT_STEPS, st.room_gain_code,
            st.hot_gain_delta, st.cold_gain_delta))
        else $error("hot saturating band does not hold full hot delta");
    a_cold_full_gain: assert property (
        st.auto_gain_comp_enable && st.band_pos <= POS_ROOM - COLD_STEPS
        |-> st.gain_code == band_gain(POS_ROOM - COLD_STEPS, st.room_gain_code,
            st.hot_gain_delta, st.cold_gain_delta))
        else $error("cold saturating band does not hold full cold delta");
    // one band per threshold event
    a_step_up: assert property (
        st.auto_gain_comp_enable && temp_valid && above && !wr_en
        && cnt_inc > {1'b0, st.filter_count_limit} && st.band_pos != POS_MAX
        |=> st.band_pos == $past(st.band_pos) + 4'h1)
        else $error("band did not step hotter");
    a_step_down: assert property (
        st.auto_gain_comp_enable && temp_valid && below && !wr_en
        && cnt_inc > {1'b0, st.filter_count_limit} && st.band_pos != '0
        |=> st.band_pos == $past(st.band_pos) - 4'h1)
        else $error("band did not step colder");
    // thresholds match the band while automatic
    a_band_thresholds: assert property (
        st.auto_gain_comp_enable |-> st.band_pos <= POS_MAX
        && st.low_threshold_reg == BAND_LOW[st.band_pos]
        && st.high_threshold_reg == BAND_HIGH[st.band_pos])
        else $error("thresholds disagree with band");
    a_band_hold: assert property (
        st.auto_gain_comp_enable && !filt_event && !wr_en |=> $stable(st.band_pos))
        else $error("band moved without a threshold event");
    a_offset_fixed: assert property (
        !(wr_en && paddr == ADDR_ROFF) |=> $stable(offset_code))
        else $error("offset code changed without a write");
    a_no_recal_auto: assert property (
        st.auto_gain_comp_enable |-> !cal_request)
        else $error("recalibration request in automatic mode");
    a_filter_count: assert property (
        temp_valid && !above && !below && st.filt_cnt != '0 && !wr_en
        |=> st.filt_cnt == $past(st.filt_cnt) - 3'h1)
        else $error("filter counter did not decrement");

    // counter counts up while the result stays outside the window
    a_count_up: assert property (
        temp_valid && (above || below) && !wr_en && cnt_inc <= {1'b0, st.filter_count_limit}
        |=> st.filt_cnt == $past(st.filt_cnt) + 3'h1)
        else $error("filter counter did not count up");

    // a threshold event always restarts the counter
    a_event_restart: assert property (
        temp_valid && (above || below) && cnt_inc > {1'b0, st.filter_count_limit}
        |=> st.filt_cnt == '0)
        else $error("filter counter not restarted by threshold event");

    // thresholds move only with a band step while automatic
    a_auto_thresh_hold: assert property (
        st.auto_gain_comp_enable && !filt_event
        |=> $stable(st.low_threshold_reg) && $stable(st.high_threshold_reg))
        else $error("thresholds changed without a band step");

    // a band step always loads a new threshold pair
    a_step_thresholds: assert property (
        st.auto_gain_comp_enable && $past(st.auto_gain_comp_enable) && $changed(st.band_pos)
        |-> $changed(st.low_threshold_reg) && $changed(st.high_threshold_reg))
        else $error("band stepped without new thresholds");

    // manual mode: an event raises the flag, even against a clear
    a_flag_set: assert property (
        !st.auto_gain_comp_enable && filt_event |=> st.cal_flag)
        else $error("threshold event did not set the recalibration flag");

    // automatic mode never raises the flag
    a_no_flag_auto: assert property (
        st.auto_gain_comp_enable && !st.cal_flag |=> !st.cal_flag)
        else $error("recalibration flag set in automatic mode");

    // main scenarios
    c_step_hot: cover property (st.auto_gain_comp_enable && st.band_pos == POS_MAX);
    c_step_cold: cover property (st.auto_gain_comp_enable && st.band_pos == '0);
    c_recal: cover property (cal_request);
    c_back_room: cover property (
        st.band_pos == POS_ROOM + 4'h1 ##[1:1000] st.band_pos == POS_ROOM);

endmodule : atgb_top

// ===== testbench/atgb_temp_source.sv
/*
 * atgb_temp_source: chip temperature result source for the tracker bench.
 * Assumes the bench calls send() from one thread and that results share pclk.
 */
`timescale 1ns/1ns
module atgb_temp_source (
    input wire logic pclk,                 // system clock
    output logic temp_valid,               // one-cycle result strobe
    output logic [15:0] chip_temp_result   // chip temperature result
);
    logic [7:0] fill = 8'h5A;              // low byte, new on every result

    ////////////////////////////////////////////////////////////////////////////
    // idle lines at time zero
    initial
    begin
        temp_valid = 1'b0;
        chip_temp_result = 16'h0000;
    end

    // one result for one cycle, then the bus stops holding the value
    task automatic send(input logic [7:0] hi);
        @(posedge pclk);
        temp_valid <= 1'b1;
        chip_temp_result <= {hi, fill};
        fill = fill + 8'h3B;
        @(posedge pclk);
        temp_valid <= 1'b0;
        chip_temp_result <= ~{hi, fill};
    endtask : send
endmodule : atgb_temp_source

// ===== testbench/test_auto_temp_gain_band_tracker.sv
/*
 * test_auto_temp_gain_band_tracker: self-checking bench with a band model.
 * Assumes atgb_pkg, atgb_top and atgb_temp_source are compiled before it.
 */
`timescale 1ns/1ns
module test_auto_temp_gain_band_tracker;
    import atgb_pkg::*;
    logic pclk = 1'b0;                     // 50 MHz clock
    logic presetn = 1'b0;                  // reset, active low
    logic psel = 1'b0;                     // apb select
    logic penable = 1'b0;                  // apb access phase
    logic pwrite = 1'b0;                   // apb direction
    logic [7:0] paddr = 8'h00;             // apb address
    logic [31:0] pwdata = 32'h0;           // apb write data
    logic [31:0] prdata;                   // apb read data
    logic pready;                          // apb ready
    logic pslverr;                         // apb error
    logic temp_valid;                      // result strobe
    logic [15:0] chip_temp_result;         // result bus
    logic [GAIN_W-1:0] gain_code;          // applied gain
    logic [OFF_W-1:0] offset_code;         // applied offset
    logic cal_request;                     // recalibration request
    // documented band thresholds, coldest first
    logic [7:0] lo [15] = '{8'h00, 8'h6B, 8'h73, 8'h7A, 8'h82, 8'h8A, 8'h92, 8'h98,
        8'h9E, 8'hA4, 8'hAA, 8'hB1, 8'hB7, 8'hBD, 8'hC3};
    logic [7:0] hi [15] = '{8'h73, 8'h7A, 8'h82, 8'h8A, 8'h92, 8'h98, 8'h9E, 8'hA4,
        8'hAA, 8'hB1, 8'hB7, 8'hBD, 8'hC3, 8'hC9, 8'hFF};
    logic [7:0] tl = 8'h8A;                // model low threshold
    logic [7:0] th = 8'h98;                // model high threshold
    logic [15:0] lf = 16'h0043;            // random state
    int pos = 5, cnt = 0, lim = 0, autoen = 0, flag = 0;
    int room = 'h200, roff = 0, hot = 0, cold = 0;
    int fails = 0, comparisons = 0, cycles = 0;
    logic [31:0] r;                        // scratch read data
    logic e;                               // scratch error
    logic [7:0] seq [7] = '{8'h91, 8'h80, 8'h7F, 8'h90, 8'hA0, 8'hA0, 8'hA0}; // manual run

    always #10 pclk = ~pclk;

    atgb_top #(.TEMP_W(16)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .temp_valid(temp_valid),
        .chip_temp_result(chip_temp_result), .gain_code(gain_code),
        .offset_code(offset_code), .cal_request(cal_request));
    atgb_temp_source src_u (.pclk(pclk), .temp_valid(temp_valid),
        .chip_temp_result(chip_temp_result));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    task automatic conclude();
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string w);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, w, got, exp);
        end
    endtask : check

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic y;
        apb(1'b1, a, d, x, y);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string w);
        logic [31:0] x;
        logic y;
        apb(1'b0, a, 32'h0, x, y);
        check(x, exp, w);
        check({31'h0, y}, 32'h0, "pslverr");
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////
    // model outputs compared with the design after every step
    task automatic verify();
        int g;
        g = room;
        if (autoen && pos > 5)
            g = room + ((hot * ((pos > 13) ? 8 : pos - 5)) >>> 3);
        if (autoen && pos < 5)
            g = room + ((cold * ((pos < 1) ? 4 : 5 - pos)) >>> 2);
        g = (g < 0) ? 0 : ((g > 1023) ? 1023 : g);
        @(negedge pclk);
        check(32'(gain_code), 32'(g), "gain");
        check(32'(offset_code), 32'(roff), "offset");
        check(32'(cal_request), 32'(autoen ? 0 : flag), "cal");
        rd_chk(ADDR_STAT, 32'((cnt << 16) | (flag << 8) | pos), "status");
        rd_chk(ADDR_TLOW, 32'(tl), "low");
        rd_chk(ADDR_THIGH, 32'(th), "high");
        rd_chk(ADDR_GOUT, 32'(g), "gout");
    endtask : verify

    // one result through the partner and the model
    task automatic sample(input logic [7:0] t);
        src_u.send(t);
        if (t > th || t < tl)
        begin
            if (cnt + 1 > lim)
            begin
                cnt = 0;
                if (autoen)
                begin
                    pos += (t > th) ? 1 : -1;
                    tl = lo[pos];
                    th = hi[pos];
                end
                else
                    flag = 1;
            end
            else
                cnt++;
        end
        else if (cnt > 0)
            cnt--;
        verify();
    endtask : sample

    task automatic enable_auto();
        wr(ADDR_CTRL, 32'h1);
        autoen = 1;
        pos = 5;
        cnt = 0;
        tl = 8'h8A;
        th = 8'h98;
        verify();
        rd_chk(ADDR_CTRL, 32'h1, "ctrl");
    endtask : enable_auto

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            conclude();
        end
    end

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        verify();
        rd_chk(ADDR_RGAIN, 32'h200, "room reset");
        apb(1'b0, 8'h24, 32'h0, r, e);
        check({31'h0, e}, 32'h1, "unmapped err");
        check(r, 32'h0, "unmapped data");
        // manual mode: counter and recalibration flag
        lf = lfsr_next(lf);
        room = lf[9:0];
        roff = lf[7:0];
        wr(ADDR_RGAIN, 32'(room));
        wr(ADDR_ROFF, 32'(roff));
        wr(ADDR_FILT, 32'h2);
        lim = 2;
        rd_chk(ADDR_FILT, 32'(lim), "limit");
        rd_chk(ADDR_ROFF, 32'(roff), "room offset");
        wr(ADDR_TLOW, 32'h80);
        tl = 8'h80;
        wr(ADDR_THIGH, 32'h90);
        th = 8'h90;
        foreach (seq[i]) sample(seq[i]);
        enable_auto();
        wr(ADDR_CTRL, 32'h0);
        autoen = 0;
        verify();
        wr(ADDR_STAT, 32'h100);
        flag = 0;
        verify();
        // automatic mode: full sweep hot then cold, random then extreme deltas
        for (int p = 0; p < 3; p++)
        begin
            lf = lfsr_next(lf);
            hot = (p == 0) ? $signed(lf[4:0]) : ((p == 1) ? 15 : -16);
            cold = (p == 0) ? $signed(lf[12:8]) : ((p == 1) ? -16 : 15);
            wr(ADDR_DELTA, 32'((cold & 31) << 8 | (hot & 31)));
            rd_chk(ADDR_DELTA, 32'((cold & 31) << 8 | (hot & 31)), "deltas");
            wr(ADDR_FILT, 32'h1);
            lim = 1;
            enable_auto();
            wr(ADDR_TLOW, 32'h11);
            verify();
            for (int i = 0; i < 9; i++)
            begin
                repeat (2) sample(th + 8'h01);
                sample(tl);
                sample(th);
            end
            for (int i = 0; i < 14; i++)
            begin
                repeat (2) sample(tl - 8'h01);
                sample(th);
                sample(tl);
            end
            wr(ADDR_CTRL, 32'h0);
            autoen = 0;
        end
        conclude();
    end
endmodule : test_auto_temp_gain_band_tracker
